/* design/scb_exec.sv */
/*
  Execution logic for the subroutine call, return and bank select
  instructions. Assumes a fetch stage presents one decoded word per issue and
  waits while busy is high; status page bits come from the status register.
  The return-address stack is eight entries deep and wraps silently, so code
  that nests deeper than that loses its oldest return address. Bit 7 of the
  file select register is written through block_write, which stands in for a
  bit set or clear of that register by the surrounding core.
*/
`timescale 1ns/1ps
module scb_exec
  import scb_pkg::*;
#(
  parameter int DEPTH = scb_pkg::STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire scb_pkg::scb_insn_t insn,
  input wire logic [2:0] page_select_bits,
  input wire logic turbo_mode,
  input wire logic block_write,
  input wire logic block_value,
  output scb_pkg::scb_core_t core,
  output logic upper_block,
  output logic busy
);
  import scb_pkg::*;

  typedef struct packed {
    scb_core_t c;
    logic [1:0] wait_cnt;
  } scb_state_t;

  scb_state_t state;
  scb_state_t next_state;
  logic push;
  logic pop;
  logic [PROG_CNT_W-1:0] ret_addr;
  logic [PROG_CNT_W-1:0] push_addr;

  function automatic logic is_call(input logic [INSN_W-1:0] w);
    return w[11:8] == CALL_OPC;
  endfunction

  function automatic logic is_bank(input logic [INSN_W-1:0] w);
    return w[11:3] == BANK_OPC;
  endfunction

  // Only the plain return is decoded; the other return forms belong elsewhere.
  function automatic logic is_ret(input logic [INSN_W-1:0] w);
    return w == RET_OPC;
  endfunction

  // A word is taken only on an enabled edge with no call in progress.
  wire logic take = ce && insn.valid && !state.c.busy;

  always_comb begin
    next_state = state;
    push = 1'b0;
    pop = 1'b0;
    if (state.c.busy) begin
      // Call occupies extra cycles with no other state changing.
      if (state.wait_cnt == 2'h1) begin
        next_state.c.busy = 1'b0;
      end
      next_state.wait_cnt = state.wait_cnt - 2'h1;
    end else if (insn.valid) begin
      if (is_call(insn.word)) begin
        push = 1'b1;
        next_state.c.program_counter[7:0] = insn.word[7:0];
        // Bit 8 held low keeps every call target in the lower half of its page.
        next_state.c.program_counter[PAGE_BIT] = 1'b0;
        next_state.c.program_counter[11:9] = page_select_bits;
        next_state.c.busy = 1'b1;
        next_state.wait_cnt = (turbo_mode ? CALL_CYC_TURBO : CALL_CYC_COMPAT) - 2'h1;
      end else if (is_ret(insn.word)) begin
        pop = 1'b1;
        next_state.c.program_counter = ret_addr;
      end else begin
        if (is_bank(insn.word)) begin
          next_state.c.file_select_register[BANK_HI:BANK_LO] = insn.word[2:0];
        end
        // Words this block does not execute still step the counter.
        next_state.c.program_counter = state.c.program_counter + PROG_CNT_W'(1);
      end
      // A call must leave the file select register alone, so a bit 7 write
      // offered together with a call is dropped rather than applied.
      if (block_write && !is_call(insn.word)) begin
        next_state.c.file_select_register[BLOCK_BIT] = block_value;
      end
    end
  end

  // The clock enable freezes the whole state; the stack is gated the same way.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{c: '{busy: 1'b0, program_counter: PROG_CNT_RESET, file_select_register: FILE_SEL_RESET},
        wait_cnt: 2'h0};
    end else if (ce) begin
      state <= next_state;
    end
  end

  // The return address wraps from the top of program memory back to zero.
  assign push_addr = state.c.program_counter + PROG_CNT_W'(1);

  scb_stack #(.DEPTH(DEPTH), .AW(PTR_W), .DW(PROG_CNT_W)) u_stack (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .push(push),
    .pop(pop),
    .push_data(push_addr),
    .top_data(ret_addr)
  );

  assign core = state.c;
  assign busy = state.c.busy;
  assign upper_block = state.c.file_select_register[BLOCK_BIT];

  call_target_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) |=> core.program_counter[7:0] == $past(insn.word[7:0]))
    else $error("call low byte wrong");
  call_bit8_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) |=> core.program_counter[8] == 1'b0)
    else $error("call bit eight not zero");
  call_page_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) |=> core.program_counter[11:9] == $past(page_select_bits))
    else $error("call page bits wrong");
  call_turbo_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) && turbo_mode ##1 ce[*2] |-> busy ##1 !busy)
    else $error("turbo call not three cycles");
  call_compat_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) && !turbo_mode ##1 ce |-> busy ##1 !busy)
    else $error("compatible call not two cycles");
  call_push_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) |=> ret_addr == $past(core.program_counter) + PROG_CNT_W'(1))
    else $error("pushed address wrong");
  call_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) |=> $stable(core.file_select_register))
    else $error("call changed file select");
  bank_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_bank(insn.word) |=> core.file_select_register[6:4] == $past(insn.word[2:0]))
    else $error("bank bits wrong");
  block_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && block_write && !is_call(insn.word) |=> upper_block == $past(block_value))
    else $error("block bit wrong");

  // The checks below pin down how long a call stays busy and what it leaves alone.
  turbo_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) && turbo_mode ##1 ce
    |-> busy ##1 busy)
    else $error("turbo call busy too short");

  call_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word)
    |=> busy)
    else $error("call did not raise busy");

  call_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_call(insn.word) && block_write
    |=> $stable(upper_block))
    else $error("call changed block select");

  busy_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy
    |=> $stable(core.program_counter) && $stable(core.file_select_register))
    else $error("state moved while busy");

  // Returns and plain words finish in one cycle.
  ret_pop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_ret(insn.word)
    |=> core.program_counter == $past(ret_addr))
    else $error("return address not restored");

  ret_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_ret(insn.word) && !block_write
    |=> $stable(core.file_select_register))
    else $error("return changed file select");

  step_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && !is_call(insn.word)
    |=> !busy)
    else $error("plain word raised busy");

  pc_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && !is_call(insn.word) && !is_ret(insn.word)
    |=> core.program_counter == $past(core.program_counter) + PROG_CNT_W'(1))
    else $error("counter did not step");

  // Bank select and block select each touch only their own bits.
  bank_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_bank(insn.word)
    |=> core.file_select_register[3:0] == $past(core.file_select_register[3:0]))
    else $error("bank changed low bits");

  bank_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && is_bank(insn.word) && !block_write
    |=> $stable(upper_block))
    else $error("bank changed block select");

  block_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    take && block_write && !is_call(insn.word) && !is_bank(insn.word)
    |=> core.file_select_register[6:0] == $past(core.file_select_register[6:0]))
    else $error("block write touched other bits");

  // Idle and disabled cycles keep every piece of state, the stack included.
  idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce && !insn.valid && !busy
    |=> $stable(core))
    else $error("state moved while idle");

  ce_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ce
    |=> $stable(core) && $stable(ret_addr))
    else $error("state moved with enable low");
endmodule // scb_exec

/* pkg/scb_pkg.sv */
/*
  Shared constants and carrier types for the subroutine call and bank select
  execution block. Assumes a 12-bit program counter and an 8-bit file select register.
*/
package scb_pkg;
  localparam int PROG_CNT_W = 12;
  localparam int FILE_SEL_W = 8;
  localparam int INSN_W = 12;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [3:0] CALL_OPC = 4'h9;
  localparam logic [8:0] BANK_OPC = 9'h003;
  localparam logic [11:0] RET_OPC = 12'h00C;
  localparam int BANK_LO = 4;
  localparam int BANK_HI = 6;
  localparam int BLOCK_BIT = 7;
  localparam int PAGE_BIT = 8;
  localparam logic [1:0] CALL_CYC_COMPAT = 2'h2;
  localparam logic [1:0] CALL_CYC_TURBO = 2'h3;
  localparam logic [PROG_CNT_W-1:0] PROG_CNT_RESET = 12'hFFF;
  localparam logic [FILE_SEL_W-1:0] FILE_SEL_RESET = 8'h00;

  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
  } scb_insn_t;

  typedef struct packed {
    logic busy;
    logic [PROG_CNT_W-1:0] program_counter;
    logic [FILE_SEL_W-1:0] file_select_register;
  } scb_core_t;
endpackage

/* design/scb_stack.sv */
/*
  Hardware return-address stack with push and pop. Assumes the caller never
  pushes and pops in one cycle; overflow wraps and overwrites the oldest entry.
*/
`timescale 1ns/1ps
module scb_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [DW-1:0] push_data,
  output logic [DW-1:0] top_data
);
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] ptr;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= '0;
    end else if (ce) begin
      if (push) begin
        ptr <= ptr + AW'(1);
      end else if (pop) begin
        ptr <= ptr - AW'(1);
      end
    end
  end

  // The array has no reset so it maps onto plain storage.
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[ptr] <= push_data;
    end
  end

  assign top_data = mem[ptr - AW'(1)];
endmodule // scb_stack

/* testbench/scb_exec_tb.sv */
/*
  Self-checking bench for the call, return and bank select execution block.
  Assumes the block answers on the taking edge itself and counts busy in clock-enable cycles.
*/
`timescale 1ns/1ps
module scb_exec_tb;
  import scb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  scb_insn_t insn = '0;
  logic [2:0] page_select_bits = 3'h0;
  logic turbo_mode = 1'b0;
  logic block_write = 1'b0;
  logic block_value = 1'b0;
  scb_core_t core;
  logic upper_block;
  logic busy;
  int err_count = 0;
  int total_checks = 0;
  always #25 clk_sys = ~clk_sys;
  scb_exec i_scb_exec (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .insn(insn),
    .page_select_bits(page_select_bits), .turbo_mode(turbo_mode), .block_write(block_write),
    .block_value(block_value), .core(core), .upper_block(upper_block), .busy(busy));
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Entered just after a rising edge; busy is counted after the taking edge under a bound.
  task automatic issue(input logic [11:0] word, input logic bw, input logic bv, output logic [11:0] n);
    // One idle edge first, so valid never falls and rises in one time step.
    @(posedge clk_sys);
    #1;
    insn.valid = 1'b1;
    insn.word = word;
    block_write = bw;
    block_value = bv;
    @(posedge clk_sys);
    #1;
    insn.valid = 1'b0;
    block_write = 1'b0;
    n = 12'h000;
    while (busy === 1'b1 && n < 12'h008) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 12'h008) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic bank_test();
    logic [11:0] n;
    issue(12'h01D, 1'b0, 1'b0, n);
    chk("bank field", {4'h0, core.file_select_register}, 12'h050);
    issue(12'h01B, 1'b1, 1'b1, n);
    chk("upper block fsr", {4'h0, core.file_select_register}, 12'h0B0);
    chk("upper block", {11'h0, upper_block}, 12'h001);
    issue(12'h01E, 1'b1, 1'b0, n);
    chk("lower block fsr", {4'h0, core.file_select_register}, 12'h060);
    chk("lower block", {11'h0, upper_block}, 12'h000);
  endtask
  task automatic call_test(input logic turbo, input logic [2:0] pg, input logic [7:0] lit);
    logic [11:0] p;
    logic [7:0] f;
    logic [11:0] n;
    turbo_mode = turbo;
    page_select_bits = pg;
    p = core.program_counter;
    f = core.file_select_register;
    issue({CALL_OPC, lit}, 1'b0, 1'b0, n);
    chk("call target", core.program_counter, {pg, 1'b0, lit});
    chk("call busy cycles", n, {10'h0, (turbo ? CALL_CYC_TURBO : CALL_CYC_COMPAT) - 2'h1});
    chk("call fsr kept", {4'h0, core.file_select_register}, {4'h0, f});
    issue(RET_OPC, 1'b0, 1'b0, n);
    chk("return address", core.program_counter, p + 12'h001);
  endtask
  // Nested calls show that the stack returns in last-in order.
  task automatic nest_test();
    logic [11:0] p;
    logic [11:0] n;
    turbo_mode = 1'b1;
    page_select_bits = 3'h2;
    p = core.program_counter;
    issue({CALL_OPC, 8'h10}, 1'b1, 1'b1, n);
    chk("call block kept", {11'h0, upper_block}, 12'h000);
    page_select_bits = 3'h5;
    issue({CALL_OPC, 8'hC3}, 1'b0, 1'b0, n);
    chk("nested target", core.program_counter, 12'hAC3);
    issue(RET_OPC, 1'b0, 1'b0, n);
    chk("inner return", core.program_counter, 12'h411);
    issue(RET_OPC, 1'b0, 1'b0, n);
    chk("outer return", core.program_counter, p + 12'h001);
  endtask
  // A low enable in the middle of a call must stretch busy and hold the counter.
  task automatic ce_test();
    logic [11:0] p;
    logic [11:0] n;
    turbo_mode = 1'b0;
    page_select_bits = 3'h1;
    @(posedge clk_sys);
    #1;
    p = core.program_counter;
    insn.valid = 1'b1;
    insn.word = {CALL_OPC, 8'h20};
    @(posedge clk_sys);
    #1;
    insn.valid = 1'b0;
    ce = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("busy frozen", {11'h0, busy}, 12'h001);
    chk("frozen target", core.program_counter, 12'h220);
    ce = 1'b1;
    @(posedge clk_sys);
    #1;
    chk("busy released", {11'h0, busy}, 12'h000);
    issue(RET_OPC, 1'b0, 1'b0, n);
    chk("frozen return", core.program_counter, p + 12'h001);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    chk("reset pc", core.program_counter, PROG_CNT_RESET);
    chk("reset busy", {11'h0, busy}, 12'h000);
    #1;
    rst_b = 1'b1;
    bank_test();
    call_test(1'b1, 3'h7, 8'hFF);
    call_test(1'b0, 3'h2, 8'h34);
    nest_test();
    ce_test();
    tally_and_finish();
  end
endmodule // scb_exec_tb
